// ### src/sdram_activate_read_path.sv
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "sdram_consts.svh"
module sdram_activate_read_path
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        cs_n_i,
  input  wire logic        ras_n_i,
  input  wire logic        cas_n_i,
  input  wire logic        we_n_i,
  input  wire logic [1:0]  ba_i,
  input  wire logic [10:0] addr_i,
  input  wire logic [3:0]  dqm_i,
  input  wire logic [31:0] dq_i,
  output logic      [31:0] dq_o,
  output logic      [3:0]  dq_oe_n_o,
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o
);
  sdram_pkg::dev_state_s s;
  sdram_pkg::dev_state_s next_s;
  sdram_pkg::cmd_e       cmd;

  logic [7:0]  col;
  logic        last;
  logic        lat2;
  logic        wlen1;
  logic        page;
  logic        rd_eng;
  logic        reading;
  logic        rd_cmd;
  logic        wr_cmd;
  logic        bst_cmd;
  logic        pre_cmd;
  logic        act_cmd;
  logic        bad_wr;
  logic        bus_we;
  logic [31:0] status;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] keep);
    logic [31:0] r;
    r = nw;
    for (int b = 0; b < 4; b++)
      if (keep[b])
        r[b*`BYTE_W +: `BYTE_W] = old[b*`BYTE_W +: `BYTE_W];
    return r;
  endfunction

  function automatic sdram_pkg::cmd_e decode(input logic cs_n, input logic [2:0] pins);
    sdram_pkg::cmd_e c;
    c = sdram_pkg::CMD_NOP;
    if (!cs_n)
    begin
      unique case (pins)
        `PIN_ACT: c = sdram_pkg::CMD_ACTIVE;
        `PIN_RD:  c = sdram_pkg::CMD_READ;
        `PIN_WR:  c = sdram_pkg::CMD_WRITE;
        `PIN_PRE: c = sdram_pkg::CMD_PRECHARGE;
        `PIN_BST: c = sdram_pkg::CMD_TERMINATE;
        `PIN_LMR: c = sdram_pkg::CMD_LOAD_MODE;
        `PIN_REF: c = sdram_pkg::CMD_REFRESH;
        default:  c = sdram_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction

  assign cmd = decode(cs_n_i, {ras_n_i, cas_n_i, we_n_i});
  assign rd_cmd = cmd == sdram_pkg::CMD_READ;
  assign wr_cmd = cmd == sdram_pkg::CMD_WRITE;
  assign bst_cmd = cmd == sdram_pkg::CMD_TERMINATE;
  assign pre_cmd = cmd == sdram_pkg::CMD_PRECHARGE;
  assign act_cmd = cmd == sdram_pkg::CMD_ACTIVE;

  // Latency codes other than two are run as three
  assign lat2 = s.mode[`LAT_MSB:`LAT_LSB] == `LAT_2;
  assign page = s.mode[`BL_MSB:`BL_LSB] == `BL_PAGE;
  assign wlen1 = s.mode[`WBM_BIT] || s.mode[`BL_MSB:`BL_LSB] == `BL_1;
  assign rd_eng = s.st == sdram_pkg::ENG_READ;
  // Engine or either pipeline stage still holds a read element
  assign reading = rd_eng || s.s1_v || s.out_v;
  // A write cutting a read whose pins were not masked the clock before
  assign bad_wr = wr_cmd && reading && (s.dqm_d1 != '1);

  //////////////////////////////////////////////////////////////////////////////
  // Column sequencing and register bus

  sdram_col_seq u_col_seq
  (
    .start_i  (s.start),
    .index_i  (s.k),
    .len_i    (s.mode[`BL_MSB:`BL_LSB]),
    .ileave_i (s.mode[`BT_BIT]),
    .col_o    (col),
    .last_o   (last)
  );

  always_comb
  begin
    status = '0;
    status[`ST_OPEN_LSB +: 4] = s.open;
    status[`ST_RD_BIT] = rd_eng;
    status[`ST_WR_BIT] = s.st == sdram_pkg::ENG_WRITE;
    status[`ST_BAD_LSB +: 8] = s.bad_cnt;
  end

  sdram_avs_slave u_avs
  (
    .sys_clk_i     (sys_clk_i),
    .resetn_i      (resetn_i),
    .address_i     (avs_address_i),
    .read_i        (avs_read_i),
    .write_i       (avs_write_i),
    .mode_i        (32'(s.mode)),
    .status_i      (status),
    .index_i       (32'(s.index)),
    .data_i        (s.mem[s.index]),
    .readdata_o    (avs_readdata_o),
    .waitrequest_o (avs_waitrequest_o),
    .write_take_o  (bus_we)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Command engine and data path

  always_comb
  begin
    logic [31:0] tmp;
    tmp = '0;
    next_s = s;
    next_s.dqm_d1 = dqm_i;
    next_s.k = s.k + 8'h01;
    // Read pipeline: engine stage, optional extra stage, pin register
    next_s.s1_v = rd_eng && !wr_cmd;
    next_s.s1_d = s.mem[col[`IDX_MSB:0]];
    next_s.out_v = (lat2 ? rd_eng : s.s1_v) && !wr_cmd;
    next_s.dq = lat2 ? s.mem[col[`IDX_MSB:0]] : s.s1_d;
    // Mask sampled one edge ago gates this load, two clocks in all
    next_s.oe_n = next_s.out_v ? s.dqm_d1 : 4'hf;
    // The row closes as the last element leaves the engine, not when it reaches the pins
    if (s.st != sdram_pkg::ENG_IDLE && last)
    begin
      next_s.st = sdram_pkg::ENG_IDLE;
      if (s.ap)
        next_s.open[s.bank] = 1'b0;
    end
    if (s.st == sdram_pkg::ENG_WRITE)
      next_s.mem[col[`IDX_MSB:0]] = merge(s.mem[col[`IDX_MSB:0]], dq_i, dqm_i);
    // Bus writes first so that a pin command on the same edge wins
    if (bus_we)
    begin
      unique case (avs_address_i)
        `REG_MODE:
        begin
          tmp = merge(32'(s.mode), avs_writedata_i, ~avs_byteenable_i);
          next_s.mode = tmp[`MODE_W-1:0];
        end
        `REG_INDEX:
        begin
          if (avs_byteenable_i[0])
            next_s.index = avs_writedata_i[`IDX_MSB:0];
        end
        `REG_DATA:
          next_s.mem[s.index] = merge(s.mem[s.index], avs_writedata_i, ~avs_byteenable_i);
        default:
          tmp = '0;
      endcase
    end
    unique case (cmd)
      sdram_pkg::CMD_ACTIVE:
        next_s.open[ba_i] = 1'b1;
      sdram_pkg::CMD_READ:
      begin
        // Restart from the new column; older elements already in flight drain out
        next_s.st = sdram_pkg::ENG_READ;
        next_s.bank = ba_i;
        next_s.start = addr_i[`COL_MSB:0];
        next_s.k = '0;
        next_s.ap = addr_i[`AP_BIT];
      end
      sdram_pkg::CMD_WRITE:
      begin
        next_s.st = sdram_pkg::ENG_IDLE;
        if (bad_wr)
          next_s.bad_cnt = s.bad_cnt + 8'h01;
        else
        begin
          next_s.mem[addr_i[`IDX_MSB:0]] = merge(s.mem[addr_i[`IDX_MSB:0]], dq_i, dqm_i);
          next_s.bank = ba_i;
          next_s.start = addr_i[`COL_MSB:0];
          next_s.k = 8'h01;
          next_s.ap = addr_i[`AP_BIT];
          if (!wlen1)
            next_s.st = sdram_pkg::ENG_WRITE;
          else if (addr_i[`AP_BIT])
            next_s.open[ba_i] = 1'b0;
        end
      end
      sdram_pkg::CMD_PRECHARGE:
      begin
        if (addr_i[`AP_BIT] || ba_i == s.bank)
          next_s.st = sdram_pkg::ENG_IDLE;
        if (addr_i[`AP_BIT])
          next_s.open = '0;
        else
          next_s.open[ba_i] = 1'b0;
      end
      sdram_pkg::CMD_TERMINATE:
        next_s.st = sdram_pkg::ENG_IDLE;
      sdram_pkg::CMD_LOAD_MODE:
        next_s.mode = addr_i[`MODE_W-1:0];
      default:
        tmp = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s <= '0;
      s.mode <= `MODE_RST;
      s.oe_n <= 4'hf;
    end
    else
      s <= next_s;
  end

  // Pins are driven only from the registered stage, never from the decode
  assign dq_o = s.dq;
  assign dq_oe_n_o = s.oe_n;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // No pin command that could start, cut or end a read
  sequence calm_s;
    !rd_cmd && !wr_cmd && !bst_cmd && !pre_cmd;
  endsequence

  sequence rd_short_s;
    rd_cmd && lat2 && s.mode[`BL_MSB:`BL_LSB] == `BL_1 ##1 calm_s ##1 calm_s;
  endsequence

  sequence rd_pair_s;
    rd_cmd && lat2 ##1 rd_cmd ##1 !wr_cmd;
  endsequence

  AST_LAT2_FIRST: assert property (
    rd_cmd && lat2 ##1 !wr_cmd |-> ##1 s.out_v)
    else $error("latency two read gave no data");

  AST_LAT3_FIRST: assert property (
    rd_cmd && !lat2 ##1 !wr_cmd [*2] |-> ##1 s.out_v)
    else $error("latency three read gave no data");

  AST_LAT3_NOT_EARLY: assert property (
    rd_cmd && !lat2 && !reading |-> ##2 !s.out_v)
    else $error("latency three data came early");

  AST_BURST_RELEASE: assert property (
    rd_short_s |-> ##1 dq_oe_n_o == 4'hf)
    else $error("pins still driven after burst end");

  AST_IDLE_RELEASE: assert property (
    !reading |=> dq_oe_n_o == 4'hf)
    else $error("pins driven with no read in flight");

  AST_PAGE_WRAP: assert property (
    (rd_eng && page && col == '1) and calm_s |=> col == '0)
    else $error("full page read did not wrap");

  AST_SEAMLESS: assert property (
    rd_pair_s |-> s.out_v ##1 s.out_v)
    else $error("gap between consecutive reads");

  AST_READ_RESTART: assert property (
    rd_cmd |=> rd_eng && s.k == '0 && col == $past(addr_i[`COL_MSB:0]))
    else $error("read not accepted at once");

  AST_MASK_OUT: assert property (
    dqm_i[0] |-> ##2 dq_oe_n_o[0])
    else $error("byte mask did not hide output");

  AST_WRITE_HIZ: assert property (
    wr_cmd |=> dq_oe_n_o == 4'hf)
    else $error("pins driven after write");

  AST_BAD_WRITE: assert property (
    bad_wr |=> s.bad_cnt == 8'($past(s.bad_cnt) + 8'h01) && s.st == sdram_pkg::ENG_IDLE)
    else $error("unmasked write cutting read not refused");

  AST_WRITE_STORE: assert property (
    wr_cmd && !bad_wr && dqm_i == '0 && !bus_we |=> s.mem[$past(addr_i[`IDX_MSB:0])] == $past(dq_i))
    else $error("unmasked write data not stored");

  AST_WRITE_SINGLE: assert property (
    wr_cmd && !bad_wr && s.mode[`WBM_BIT] |=> s.st == sdram_pkg::ENG_IDLE)
    else $error("single write mode ran a burst");

  AST_AUTO_PRE: assert property (
    (rd_eng && last && s.ap && !act_cmd) and calm_s |=> !s.open[$past(s.bank)])
    else $error("auto precharge left row open");

  AST_TERMINATE: assert property (
    bst_cmd && lat2 |-> ##2 !s.out_v)
    else $error("terminate did not stop read data");
endmodule

// ### src/sdram_avs_slave.sv
`timescale 1ns/1ps
`include "sdram_consts.svh"
module sdram_avs_slave
(
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] mode_i,
  input  wire logic [31:0] status_i,
  input  wire logic [31:0] index_i,
  input  wire logic [31:0] data_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  output logic             write_take_o
);
  sdram_pkg::bus_state_s s;
  sdram_pkg::bus_state_s next_s;

  // One wait cycle per access; data is latched while the request waits
  always_comb
  begin
    next_s = s;
    next_s.busy = 1'b1;
    if (s.busy && (read_i || write_i))
    begin
      next_s.busy = 1'b0;
      unique case (address_i)
        `REG_MODE:   next_s.rdata = mode_i;
        `REG_STATUS: next_s.rdata = status_i;
        `REG_INDEX:  next_s.rdata = index_i;
        `REG_DATA:   next_s.rdata = data_i;
        default:     next_s.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s <= '0;
      s.busy <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign readdata_o = s.rdata;
  assign waitrequest_o = s.busy;
  assign write_take_o = write_i && !s.busy;
endmodule

// ### src/sdram_col_seq.sv
`timescale 1ns/1ps
`include "sdram_consts.svh"
module sdram_col_seq
(
  input  wire logic [7:0] start_i,
  input  wire logic [7:0] index_i,
  input  wire logic [2:0] len_i,
  input  wire logic       ileave_i,
  output logic      [7:0] col_o,
  output logic            last_o
);
  logic [7:0] mask;
  logic [7:0] walk;

  always_comb
  begin
    unique case (len_i)
      `BL_2:    mask = `MASK_2;
      `BL_4:    mask = `MASK_4;
      `BL_8:    mask = `MASK_8;
      `BL_PAGE: mask = `MASK_PAGE;
      default:  mask = `MASK_1;
    endcase
  end

  // Full page has no interleaved order, so it always counts upward
  assign walk = (ileave_i && len_i != `BL_PAGE) ? (start_i ^ index_i) : (start_i + index_i);
  assign col_o = (start_i & ~mask) | (walk & mask);
  assign last_o = (len_i != `BL_PAGE) && (index_i == mask);
endmodule

// ### src/sdram_consts.svh
`ifndef SDRAM_CONSTS_SVH
`define SDRAM_CONSTS_SVH
// Mode word fields
`define BL_LSB 0
`define BL_MSB 2
`define BT_BIT 3
`define LAT_LSB 4
`define LAT_MSB 6
`define OPM_LSB 7
`define OPM_MSB 8
`define WBM_BIT 9
`define MODE_W 10
`define MODE_RST 10'h020
// Burst length codes and the column block masks they select
`define BL_1 3'h0
`define BL_2 3'h1
`define BL_4 3'h2
`define BL_8 3'h3
`define BL_PAGE 3'h7
`define MASK_1 8'h00
`define MASK_2 8'h01
`define MASK_4 8'h03
`define MASK_8 8'h07
`define MASK_PAGE 8'hff
`define LAT_2 3'h2
// Address pin roles
`define AP_BIT 10
`define COL_MSB 7
`define IDX_MSB 3
`define BYTE_W 8
// Command pin codes on {ras_n, cas_n, we_n}
`define PIN_ACT 3'h3
`define PIN_RD 3'h5
`define PIN_WR 3'h4
`define PIN_PRE 3'h2
`define PIN_BST 3'h6
`define PIN_LMR 3'h0
`define PIN_REF 3'h1
// Register byte offsets and status fields
`define REG_MODE 5'h00
`define REG_STATUS 5'h04
`define REG_INDEX 5'h08
`define REG_DATA 5'h0c
`define ST_OPEN_LSB 0
`define ST_RD_BIT 4
`define ST_WR_BIT 5
`define ST_BAD_LSB 8
`endif

// ### src/sdram_pkg.sv
`include "sdram_consts.svh"
package sdram_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_TERMINATE, CMD_LOAD_MODE, CMD_REFRESH
  } cmd_e;
  typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} eng_e;
  typedef struct packed {
    logic [`MODE_W-1:0] mode;
    logic [3:0]         open;
    eng_e               st;
    logic [1:0]         bank;
    logic [7:0]         start;
    logic [7:0]         k;
    logic               ap;
    logic               s1_v;
    logic [31:0]        s1_d;
    logic               out_v;
    logic [31:0]        dq;
    logic [3:0]         oe_n;
    logic [3:0]         dqm_d1;
    logic [7:0]         bad_cnt;
    logic [3:0]         index;
    logic [15:0][31:0]  mem;
  } dev_state_s;
  typedef struct packed {
    logic        busy;
    logic [31:0] rdata;
  } bus_state_s;
endpackage

// ### verif/sdram_activate_read_path_tb.sv
`timescale 1ns/1ps
`include "sdram_consts.svh"
module sdram_activate_read_path_tb;
  logic        sys_clk, resetn, cs_n, ras_n, cas_n, we_n, avs_rdq, avs_wrq, avs_wait, il, ap;
  logic [1:0]  ba, b;
  logic [10:0] addr;
  logic [3:0]  dqm, dq_oe_n, avs_be, c, dm;
  logic [31:0] dq_w, dq_r, avs_wd, avs_rd, r, x, d;
  logic [4:0]  avs_addr;
  logic [2:0]  bl;
  logic [7:0]  s;
  logic [31:0] mem_m [16];
  logic [35:0] got [$];
  int          n_mismatch, check_count, cyc, bad_n, m;
  always #25 sys_clk = ~sys_clk;
  sdram_ctl_model ctl_u (.sys_clk_i(sys_clk), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
    .we_n_o(we_n), .ba_o(ba), .addr_o(addr), .dqm_o(dqm), .dq_o(dq_w));
  sdram_activate_read_path dut_u (.sys_clk_i(sys_clk), .resetn_i(resetn), .cs_n_i(cs_n),
    .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .ba_i(ba), .addr_i(addr), .dqm_i(dqm),
    .dq_i(dq_w), .dq_o(dq_r), .dq_oe_n_o(dq_oe_n), .avs_address_i(avs_addr),
    .avs_read_i(avs_rdq), .avs_write_i(avs_wrq), .avs_writedata_i(avs_wd),
    .avs_byteenable_i(avs_be), .avs_readdata_o(avs_rd), .avs_waitrequest_o(avs_wait));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] g, input logic [35:0] e, input string what);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] v,
                    output logic [31:0] q);
    @(posedge sys_clk);
    avs_wrq <= wr;
    avs_rdq <= !wr;
    avs_addr <= a;
    avs_wd <= v;
    do @(posedge sys_clk); while (avs_wait !== 1'b0);
    q = avs_rd;
    avs_wrq <= 1'b0;
    avs_rdq <= 1'b0;
  endtask
  task automatic word(input logic [3:0] i, output logic [31:0] q);
    logic [31:0] t;
    av(1'b1, `REG_INDEX, {28'h0, i}, t);
    av(1'b0, `REG_DATA, 32'h0, q);
  endtask
  // Pin samples taken mid-cycle; index j is what edge n+j shows for a command at n
  task automatic rec(input int n);
    got.delete();
    repeat (n)
    begin
      @(negedge sys_clk);
      got.push_back({dq_oe_n, dq_r});
    end
  endtask
  function automatic logic [7:0] colk(input logic [7:0] st, input int k, input logic [2:0] l,
                                      input logic lv);
    logic [7:0] mk;
    mk = (l == `BL_PAGE) ? 8'hff : 8'((1 << l) - 1);
    return (st & ~mk) | ((lv ? (st ^ 8'(k)) : (st + 8'(k))) & mk);
  endfunction
  // Enabled byte lanes take the new word, the others keep the old one
  function automatic logic [31:0] lanes(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] e);
    logic [31:0] w;
    w = o;
    for (int y = 0; y < 4; y++)
      if (e[y])
        w[y*8 +: 8] = n[y*8 +: 8];
    return w;
  endfunction
  task automatic burst(input int j, input int n, input logic [7:0] st, input logic [2:0] l,
                       input logic lv);
    for (int k = 0; k < n; k++)
      chk(got[j + k], {dm, mem_m[4'(colk(st, k, l, lv))]}, "read data");
  endtask
  task automatic off(input int j);
    chk({got[j][35:32], 32'h0}, {4'hf, 32'h0}, "pins released");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {sys_clk, resetn, avs_rdq, avs_wrq, cyc, bad_n, n_mismatch, check_count} = '0;
    {avs_addr, avs_wd, dm} = '0;
    avs_be = 4'hf;
    void'($urandom(32'hbd16a116));
    repeat (10) @(posedge sys_clk);
    chk({dq_oe_n, 31'h0, avs_wait}, {4'hf, 31'h0, 1'b1}, "reset outputs");
    resetn <= 1'b1;
    av(1'b0, `REG_MODE, 32'h0, r);
    chk({26'h0, r[9:0]}, {26'h0, `MODE_RST}, "mode reset");
    av(1'b0, `REG_STATUS, 32'h0, r);
    chk({4'h0, r}, 36'h0, "status reset");
    avs_be <= 4'h0;
    av(1'b1, `REG_MODE, 32'h3ff, x);
    avs_be <= 4'hf;
    av(1'b0, `REG_MODE, 32'h0, r);
    chk({26'h0, r[9:0]}, {26'h0, `MODE_RST}, "masked write");
    av(1'b0, 5'h10, 32'h0, r);
    chk({4'h0, r}, 36'h0, "unmapped read");
    for (int i = 0; i < 16; i++)
    begin
      d = $urandom;
      c = 4'($urandom);
      mem_m[i] = lanes(32'h0, d, c);
      avs_be <= 4'hf;
      av(1'b1, `REG_INDEX, i, x);
      avs_be <= c;
      av(1'b1, `REG_DATA, d, x);
    end
    avs_be <= 4'hf;
    word(4'h5, r);
    chk({4'h0, r}, {4'h0, mem_m[5]}, "store word");
    $display("test registers done");
    for (int i = 0; i < 12; i++)
    begin
      m = 2 + $urandom_range(1);
      bl = (i < 4) ? 3'(i) : 3'($urandom_range(3));
      il = 1'($urandom_range(1));
      s = 8'($urandom);
      b = 2'($urandom);
      ap = 1'($urandom_range(1));
      ctl_u.load_mode({3'b000, 3'(m), il, bl});
      ctl_u.open_row(b, 11'($urandom));
      dm = 4'($urandom);
      ctl_u.mask(dm);
      ctl_u.cmd(`PIN_RD, b, {ap, 2'b00, s});
      fork
        rec(m + (1 << bl) + 2);
        ctl_u.nop(m + (1 << bl) + 2);
      join
      burst(m, 1 << bl, s, bl, il);
      off(m + (1 << bl));
      dm = 4'h0;
      ctl_u.mask(4'h0);
      av(1'b0, `REG_STATUS, 32'h0, r);
      chk({35'h0, r[b]}, {35'h0, !ap}, "row open after burst");
      if (ap)
        ctl_u.shut(b);
    end
    $display("test random bursts done");
    for (int t = 0; t < 4; t++)
    begin
      m = 2 + t % 2;
      ctl_u.load_mode({3'b000, 3'(m), 1'b0, `BL_PAGE});
      ctl_u.open_row(2'h0, 11'h012);
      ctl_u.cmd(`PIN_RD, 2'h0, 11'h0fd);
      fork
        rec(m + 8);
        begin
          ctl_u.nop(4);
          ctl_u.cmd(t > 1 ? `PIN_PRE : `PIN_BST, 2'h0, 11'h000);
          ctl_u.nop(m + 3);
        end
      join
      burst(m, 5, 8'hfd, `BL_PAGE, 1'b0);
      off(m + 5);
      if (t > 1)
        ctl_u.shut(2'h0);
    end
    $display("test page wrap done");
    for (int t = 0; t < 2; t++)
    begin
      m = 2 + t;
      ctl_u.load_mode({3'b000, 3'(m), 1'b0, `BL_4});
      for (int i = 0; i < 4; i++)
        ctl_u.open_row(2'(i), 11'($urandom));
      ctl_u.cmd(`PIN_RD, 2'h0, 11'h010);
      fork
        rec(m + 8);
        begin
          ctl_u.cmd(`PIN_RD, 2'h1, 11'h021);
          ctl_u.cmd(`PIN_RD, 2'h2, 11'h033);
          ctl_u.nop(m + 6);
        end
      join
      burst(m, 1, 8'h10, `BL_4, 1'b0);
      burst(m + 1, 1, 8'h21, `BL_4, 1'b0);
      burst(m + 2, 4, 8'h33, `BL_4, 1'b0);
      off(m + 6);
    end
    $display("test back to back done");
    for (int g = 0; g < 2; g++)
    begin
      d = $urandom;
      c = 4'h8 | 4'($urandom_range(7));
      ctl_u.load_mode({1'b1, 2'b00, 3'h2, 1'b0, `BL_8});
      ctl_u.open_row(2'h0, 11'h034);
      ctl_u.cmd(`PIN_RD, 2'h0, 11'h040);
      fork
        rec(10);
        begin
          ctl_u.nop(2);
          if (g)
            ctl_u.mask(4'hf);
          ctl_u.nop(1);
          ctl_u.cmd(`PIN_WR, 2'h0, {7'h00, c}, d);
          ctl_u.mask(4'h0);
          ctl_u.nop(6);
        end
      join
      burst(2, 2, 8'h40, `BL_8, 1'b0);
      if (g)
        off(4);
      else
        burst(4, 1, 8'h42, `BL_8, 1'b0);
      off(5);
      if (g)
        mem_m[c] = d;
      bad_n += !g;
      word(c, r);
      chk({4'h0, r}, {4'h0, mem_m[c]}, "write after read");
      av(1'b0, `REG_STATUS, 32'h0, r);
      chk({28'h0, r[15:8]}, 36'(bad_n), "refused writes");
    end
    $display("test read to write done");
    for (int w = 0; w < 2; w++)
    begin
      d = $urandom;
      ctl_u.load_mode({1'(w), 2'b00, 3'h2, 1'b0, `BL_4});
      ctl_u.cmd(`PIN_WR, 2'h1, 11'h008, d);
      ctl_u.nop(5);
      for (int k = 0; k < 4; k++)
        if (!w || k == 0)
          mem_m[8 + k] = k[0] ? ~d : d;
      for (int k = 0; k < 4; k++)
      begin
        word(4'(8 + k), r);
        chk({4'h0, r}, {4'h0, mem_m[8 + k]}, "write burst mode");
      end
    end
    $display("test write burst mode done");
    wrap_up();
  end
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
endmodule

// ### verif/sdram_ctl_model.sv
`timescale 1ns/1ps
`include "sdram_consts.svh"
module sdram_ctl_model
#(
  parameter int TRCD_NS = 20,
  parameter int TRRD_NS = 20,
  parameter int TRP_NS  = 20,
  parameter int TCK_NS  = 50
)
(
  input  wire logic        sys_clk_i,
  output logic             cs_n_o,
  output logic             ras_n_o,
  output logic             cas_n_o,
  output logic             we_n_o,
  output logic      [1:0]  ba_o,
  output logic      [10:0] addr_o,
  output logic      [3:0]  dqm_o,
  output logic      [31:0] dq_o
);
  // Time limits rounded up to whole cycles
  localparam int TRCD = (TRCD_NS + TCK_NS - 1) / TCK_NS;
  localparam int TRRD = (TRRD_NS + TCK_NS - 1) / TCK_NS;
  localparam int TRP  = (TRP_NS + TCK_NS - 1) / TCK_NS;
  logic [3:0] open_m;
  initial
  begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
    ba_o = 2'h0;
    addr_o = 11'h000;
    dqm_o = 4'h0;
    dq_o = 32'h5a5a0f0f;
    open_m = 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Data lines have no pull: outside a write they toggle with every command the model issues
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [10:0] a,
                     input logic [31:0] d = 32'h0);
    logic desel;
    // A NOP may come as a deselect, with junk on the command pins
    desel = (c == 3'h7) && ($urandom_range(1) == 1);
    @(posedge sys_clk_i);
    cs_n_o <= desel;
    {ras_n_o, cas_n_o, we_n_o} <= desel ? 3'($urandom) : c;
    ba_o <= b;
    addr_o <= a;
    dq_o <= (c == `PIN_WR) ? d : ~dq_o;
  endtask
  task automatic nop(input int n);
    repeat (n) cmd(3'h7, 2'h0, 11'h000);
  endtask
  task automatic mask(input logic [3:0] v);
    dqm_o <= v;
  endtask
  task automatic load_mode(input logic [9:0] m);
    cmd(`PIN_LMR, 2'h0,
        {1'b0, m[9], 2'b00, (m[6:4] == 3'h3) ? 3'h3 : 3'h2, m[3:0]});
  endtask
  task automatic open_row(input logic [1:0] b, input logic [10:0] row);
    if (!open_m[b])
    begin
      cmd(`PIN_ACT, b, row);
      open_m[b] = 1'b1;
      nop((TRCD > TRRD ? TRCD : TRRD) - 1);
    end
  endtask
  task automatic shut(input logic [1:0] b);
    open_m[b] = 1'b0;
    nop(TRP);
  endtask
endmodule
